// *** logic/wlm_consts.svh ***
// register offsets, field positions, reset values and timing counts of the line monitor
`ifndef WLM_CONSTS_SVH
`define WLM_CONSTS_SVH
`define WLM_ADDR_W           6
`define WLM_OFF_WAVEFORM     6'h01
`define WLM_OFF_PERIOD       6'h07
`define WLM_OFF_MEASUREMENT_MODE        6'h0B
`define WLM_OFF_WAVMODE      6'h0C
`define WLM_OFF_IRQ_EN       6'h0F
`define WLM_OFF_STATUS       6'h10
`define WLM_OFF_COR_STATUS   6'h11
`define WLM_OFF_ZX_TIMEOUT   6'h12
`define WLM_OFF_SAG_CYC      6'h13
`define WLM_OFF_SAG_LVL      6'h14
`define WLM_OFF_GAIN_A       6'h19
`define WLM_OFF_GAIN_B       6'h1A
`define WLM_OFF_GAIN_C       6'h1B
`define WLM_RST_MEASUREMENT_MODE        8'h70
`define WLM_RST_WAVMODE      8'h00
`define WLM_RST_IRQ_EN       10'h000
`define WLM_RST_ZX_TIMEOUT   16'hFFFF
`define WLM_RST_SAG_CYC      8'hFF
`define WLM_RST_SAG_LVL      8'h00
`define WLM_MM_PERSEL_LSB    0
`define WLM_MM_CROSSING_PHASE_SELECT_LSB     4
`define WLM_WM_SRC_LSB       0
`define WLM_WM_RATE_LSB      3
`define WLM_ST_WAVE          0
`define WLM_ST_SAG_LSB       1
`define WLM_ST_CROSSING_TIMEOUT_FLAG_LSB      4
`define WLM_ST_ZX_LSB        7
`define WLM_CUR_POS_LIM      24'h400000
`define WLM_CUR_NEG_LIM      24'hC00000
`define WLM_LPF_SHIFT        4
`define WLM_CLK_PERIOD_NS    100
`define WLM_CROSSING_TIMEOUT_FLAG_TICK_CYC    384
`define WLM_PERIOD_LSB_NS    2400
`define WLM_PERIOD_TICK_CYC  (`WLM_PERIOD_LSB_NS / `WLM_CLK_PERIOD_NS)
`define WLM_PERIOD_MAX       15'h7FFF
`endif

// *** logic/wlm_pkg.sv ***
// types shared by the line monitor
package wlm_pkg;
  typedef logic signed [2:0][23:0] wlm_cur_t;   // three current samples, phase a in [0]
  typedef logic signed [2:0][15:0] wlm_volt_t;  // three voltage samples, phase a in [0]
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } wlm_reg_req_t;
  typedef enum logic [1:0] {
    WLM_SER_IDLE = 2'h0,
    WLM_SER_HI   = 2'h1,
    WLM_SER_MID  = 2'h3,
    WLM_SER_LO   = 2'h2
  } wlm_ser_state_t;
endpackage : wlm_pkg

// *** logic/wlm_top.sv ***
// waveform line monitor: current clamp and gain, voltage filter, capture, crossings, period, sag
// Summary of operation
// RL1: clamp overranged current samples to 400000h and C00000h.
// RL2: scale each current sample by one plus signed gain over 4096.
// RL3: capture rate from waveform-mode bits 3 and 4, four rates.
// RL4: irq low on each new waveform sample when sample-ready enable set.
// RL5: waveform register never loads while sample-ready enable is zero.
// RL6: waveform words leave as three bytes, most significant first.
// RL7: irq stays low until the clear-on-read status is read.
// RL8: current scaling keeps running regardless of waveform capture.
// RL9: voltage samples pass a single-pole 260 Hz low-pass filter first.
// RL10: voltage word sits in low 16 bits, top byte zero.
// RL11: crossings are taken from the filtered voltage.
// RL12: rising crossing sets that phase's flag in status bits 7 to 9.
// RL13: crossing irq only when that phase's crossing enable is set.
// RL14: clear-on-read status read clears the crossing flags.
// RL15: crossing select bits in measurement mode also gate crossing irqs.
// RL16: per-phase 16-bit down-counter, tick every 384 clocks, reload on crossing.
// RL17: counter reaching zero sets timeout flag; irq gated by sag enable.
// RL18: crossing select zero holds that phase's timeout flag set.
// RL19: 15-bit period updated each cycle of chosen phase, 2.4 us steps.
// RL20: host picks period phase and enables same phase in crossing select.
// RL21: sag flag set at end of final counted low half cycle.
// RL22: sag irq only when that phase's sag enable is set.
// RL23: all phases share one sag level and one half-cycle count.
// RL24: sagging when level byte exceeds absolute upper byte of voltage.
// RL25: a half cycle at or above level restarts the sag count.
// RL26: irq is the OR of every flag ANDed with its enable, the timeout flags with the sag enables; crossing and timeout terms also need crossing select.
`timescale 1ns/1ps
`default_nettype none
`include "wlm_consts.svh"
module wlm_top
  import wlm_pkg::*;
(
  input  wire logic         i_clk,             // 10 MHz device clock
  input  wire logic         i_sys_rst,         // async reset, active high
  input  wire logic         i_smp_valid,       // one-cycle pulse, new converter samples
  input  wire wlm_cur_t     i_cur_raw,         // raw current samples
  input  wire wlm_volt_t    i_volt_raw,        // raw voltage samples
  input  wire wlm_reg_req_t i_reg,             // register access request
  output logic [15:0]       o_reg_rdata,       // read data, one cycle after rd
  output wlm_cur_t          o_cur_scaled,      // clamped and gain-scaled current
  output logic              o_cur_valid,       // pulse with o_cur_scaled
  output logic [7:0]        o_wave_byte,       // waveform byte stream
  output logic              o_wave_byte_valid, // byte is offered
  input  wire logic         i_wave_byte_ready, // receiver takes the byte
  output logic              o_irq_n,           // interrupt request, active low
  output logic              o_irq_oe           // high while the open-drain pin is pulled
);

  // clamp an overranged current sample
  function automatic logic signed [23:0] wlm_clamp(input logic signed [23:0] x);
    if (x > $signed(`WLM_CUR_POS_LIM))
      return `WLM_CUR_POS_LIM;
    else if (x < $signed(`WLM_CUR_NEG_LIM))
      return `WLM_CUR_NEG_LIM;
    else
      return x;
  endfunction : wlm_clamp

  // absolute value of the upper byte of a voltage sample
  function automatic logic [7:0] wlm_abs_msb(input logic signed [15:0] v);
    logic signed [7:0] b;
    b = v[15:8];
    return b[7] ? 8'(-b) : 8'(b);
  endfunction : wlm_abs_msb

  // registers
  logic [7:0]        measurement_mode_q;
  logic [7:0]        wavmode_q;
  logic [9:0]        irq_en_q;
  logic [9:0]        status_q;
  logic [15:0]       zx_timeout_q;
  logic [7:0]        sag_cyc_q;
  logic [7:0]        sag_lvl_q;
  logic [2:0][11:0]  gain_q;
  logic [23:0]       wave_q;
  logic [14:0]       period_q;

  // register decode
  wire        reg_wr   = i_reg.wr;
  wire        cor_rd   = i_reg.rd && (i_reg.addr == `WLM_OFF_COR_STATUS);
  wire [2:0]  zx_sel   = measurement_mode_q[`WLM_MM_CROSSING_PHASE_SELECT_LSB +: 3];
  wire [1:0]  per_sel  = measurement_mode_q[`WLM_MM_PERSEL_LSB +: 2];
  wire [2:0]  wv_src   = wavmode_q[`WLM_WM_SRC_LSB +: 3];
  wire [1:0]  wv_rate  = wavmode_q[`WLM_WM_RATE_LSB +: 2];
  wire        smp_rdy_en = irq_en_q[`WLM_ST_WAVE];

  // register writes; status is read-only
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      measurement_mode_q      <= `WLM_RST_MEASUREMENT_MODE;
      wavmode_q    <= `WLM_RST_WAVMODE;
      irq_en_q     <= `WLM_RST_IRQ_EN;
      zx_timeout_q <= `WLM_RST_ZX_TIMEOUT;
      sag_cyc_q    <= `WLM_RST_SAG_CYC;
      sag_lvl_q    <= `WLM_RST_SAG_LVL;
      gain_q       <= '0;
    end else if (reg_wr) begin
      case (i_reg.addr)
        `WLM_OFF_MEASUREMENT_MODE:      measurement_mode_q      <= i_reg.wdata[7:0];
        `WLM_OFF_WAVMODE:    wavmode_q    <= i_reg.wdata[7:0];
        `WLM_OFF_IRQ_EN:     irq_en_q     <= i_reg.wdata[9:0];
        `WLM_OFF_ZX_TIMEOUT: zx_timeout_q <= i_reg.wdata;
        `WLM_OFF_SAG_CYC:    sag_cyc_q    <= i_reg.wdata[7:0];
        `WLM_OFF_SAG_LVL:    sag_lvl_q    <= i_reg.wdata[7:0];
        `WLM_OFF_GAIN_A:     gain_q[0]    <= i_reg.wdata[11:0];
        `WLM_OFF_GAIN_B:     gain_q[1]    <= i_reg.wdata[11:0];
        `WLM_OFF_GAIN_C:     gain_q[2]    <= i_reg.wdata[11:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  logic [15:0] rd_mux;
  always_comb begin
    case (i_reg.addr)
      `WLM_OFF_WAVEFORM:   rd_mux = wave_q[15:0];
      `WLM_OFF_PERIOD:     rd_mux = {1'b0, period_q};
      `WLM_OFF_MEASUREMENT_MODE:      rd_mux = {8'h00, measurement_mode_q};
      `WLM_OFF_WAVMODE:    rd_mux = {8'h00, wavmode_q};
      `WLM_OFF_IRQ_EN:     rd_mux = {6'h00, irq_en_q};
      `WLM_OFF_STATUS:     rd_mux = {6'h00, status_q};
      `WLM_OFF_COR_STATUS: rd_mux = {6'h00, status_q};
      `WLM_OFF_ZX_TIMEOUT: rd_mux = zx_timeout_q;
      `WLM_OFF_SAG_CYC:    rd_mux = {8'h00, sag_cyc_q};
      `WLM_OFF_SAG_LVL:    rd_mux = {8'h00, sag_lvl_q};
      `WLM_OFF_GAIN_A:     rd_mux = {4'h0, gain_q[0]};
      `WLM_OFF_GAIN_B:     rd_mux = {4'h0, gain_q[1]};
      `WLM_OFF_GAIN_C:     rd_mux = {4'h0, gain_q[2]};
      default:             rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_reg_rdata <= 16'h0000;
    else if (i_reg.rd)
      o_reg_rdata <= rd_mux;
  end

  // current path: clamp then gain, every sample whether or not capture runs
  wlm_cur_t cur_clamp;
  wlm_cur_t cur_scale;
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_cur
      wire signed [36:0] prod;
      assign cur_clamp[gp] = wlm_clamp($signed(i_cur_raw[gp]));       // see RL1
      assign prod = 37'($signed(cur_clamp[gp])) *
                    37'(14'sh1000 + 14'($signed(gain_q[gp]))); // see RL2
      assign cur_scale[gp] = prod[35:12];
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cur_scaled <= '0;
      o_cur_valid  <= 1'b0;
    end else begin
      o_cur_valid <= i_smp_valid;
      if (i_smp_valid)
        o_cur_scaled <= cur_scale; // see RL8
    end
  end

  // voltage low-pass: y += (x - y) / 16, corner near 260 Hz at 26 kSPS
  logic signed [2:0][19:0] lpf_acc_q;
  wlm_volt_t flt_q;
  wlm_volt_t flt_prev_q;
  logic      upd_q;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lpf_acc_q  <= '0;
      flt_q      <= '0;
      flt_prev_q <= '0;
      upd_q      <= 1'b0;
    end else begin
      upd_q <= i_smp_valid;
      if (i_smp_valid) begin
        for (int i = 0; i < 3; i++) begin
          lpf_acc_q[i]  <= 20'($signed(lpf_acc_q[i]) + $signed(i_volt_raw[i])
                           - ($signed(lpf_acc_q[i]) >>> `WLM_LPF_SHIFT)); // see RL9
          flt_q[i]      <= lpf_acc_q[i][19:4];
          flt_prev_q[i] <= flt_q[i];
        end
      end
    end
  end

  // crossing and half-cycle events from the filtered voltage
  logic [2:0] zx_ev;
  logic [2:0] hc_ev;
  logic [2:0][7:0] mag;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_zx
      assign zx_ev[gp] = upd_q && flt_prev_q[gp][15] && !flt_q[gp][15]; // see RL11
      assign hc_ev[gp] = upd_q && (flt_prev_q[gp][15] ^ flt_q[gp][15]);
      assign mag[gp]   = wlm_abs_msb($signed(flt_q[gp]));                // see RL24
    end
  endgenerate

  // crossing timeout counters, one tick every 384 clocks
  logic [8:0]       to_pre_q;
  logic [2:0][15:0] to_cnt_q;
  logic [2:0]       to_ev;
  wire              to_tick = (to_pre_q == 9'(`WLM_CROSSING_TIMEOUT_FLAG_TICK_CYC - 1));
  generate
    for (gp = 0; gp < 3; gp++) begin : g_to
      assign to_ev[gp] = to_tick && !zx_ev[gp] && (to_cnt_q[gp] == 16'h0001); // see RL17
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      to_pre_q <= '0;
      to_cnt_q <= {3{`WLM_RST_ZX_TIMEOUT}};
    end else begin
      to_pre_q <= to_tick ? 9'h000 : 9'(to_pre_q + 9'h001);
      for (int i = 0; i < 3; i++) begin
        if (zx_ev[i])
          to_cnt_q[i] <= zx_timeout_q;                  // see RL16
        else if (to_tick && to_cnt_q[i] != 16'h0000)
          to_cnt_q[i] <= 16'(to_cnt_q[i] - 16'h0001);   // see RL16
      end
    end
  end

  // period of the selected phase in 2.4 us steps
  logic [4:0]  per_pre_q;
  logic [14:0] per_cnt_q;
  wire         per_tick = (per_pre_q == 5'(`WLM_PERIOD_TICK_CYC - 1));
  wire         per_ev   = (per_sel != 2'h3) && zx_ev[per_sel] && zx_sel[per_sel]; // see RL20
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      per_pre_q <= '0;
      per_cnt_q <= '0;
      period_q  <= '0;
    end else begin
      per_pre_q <= per_tick ? 5'h00 : 5'(per_pre_q + 5'h01);
      if (per_ev) begin
        period_q  <= per_cnt_q;                          // see RL19
        per_cnt_q <= '0;
      end else if (per_tick && per_cnt_q != `WLM_PERIOD_MAX)
        per_cnt_q <= 15'(per_cnt_q + 15'h0001);
    end
  end

  // sag detection against the shared level and half-cycle count
  logic [2:0][7:0] pk_q;
  logic [2:0][7:0] sag_cnt_q;
  logic [2:0][7:0] pk_end;
  logic [2:0]      hc_low;
  logic [2:0]      sag_ev;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_sag
      assign pk_end[gp] = (mag[gp] > pk_q[gp]) ? mag[gp] : pk_q[gp];
      assign hc_low[gp] = sag_lvl_q > pk_end[gp];                          // see RL23
      assign sag_ev[gp] = hc_ev[gp] && hc_low[gp] &&
                          (8'(sag_cnt_q[gp] + 8'h01) == sag_cyc_q);        // see RL21
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pk_q      <= '0;
      sag_cnt_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (hc_ev[i]) begin
          pk_q[i] <= 8'h00;
          if (!hc_low[i])
            sag_cnt_q[i] <= 8'h00;                      // see RL25
          else if (sag_cnt_q[i] != 8'hFF)
            sag_cnt_q[i] <= 8'(sag_cnt_q[i] + 8'h01);
        end else if (upd_q)
          pk_q[i] <= pk_end[i];
      end
    end
  end

  // capture decimation and two-entry word buffer
  logic [2:0]       dec_q;
  logic [1:0][23:0] fifo_mem_q;
  logic             fifo_wp_q;
  logic             fifo_rp_q;
  logic [1:0]       fifo_cnt_q;
  wire  [2:0]       dec_mask  = 3'((4'h1 << wv_rate) - 4'h1);
  wire              dec_hit   = ((dec_q & dec_mask) == 3'h0);                // see RL3
  wire              fifo_in_rdy = (fifo_cnt_q != 2'h2);
  wire              fifo_out_vld = (fifo_cnt_q != 2'h0);
  wire              cap_go    = upd_q && dec_hit && smp_rdy_en && fifo_in_rdy; // see RL5
  wire              fifo_pop;
  logic [23:0]      cap_word;
  always_comb begin
    case (wv_src)
      3'h0, 3'h1, 3'h2: cap_word = o_cur_scaled[wv_src[1:0]];
      3'h3:             cap_word = {8'h00, flt_q[0]};                         // see RL10
      3'h4:             cap_word = {8'h00, flt_q[1]};
      3'h5:             cap_word = {8'h00, flt_q[2]};
      default:          cap_word = 24'h000000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dec_q      <= '0;
      wave_q     <= '0;
      fifo_mem_q <= '0;
      fifo_wp_q  <= 1'b0;
      fifo_rp_q  <= 1'b0;
      fifo_cnt_q <= '0;
    end else begin
      if (upd_q)
        dec_q <= 3'(dec_q + 3'h1);
      if (cap_go) begin
        wave_q                <= cap_word;
        fifo_mem_q[fifo_wp_q] <= cap_word;
        fifo_wp_q             <= !fifo_wp_q;
      end
      if (fifo_pop)
        fifo_rp_q <= !fifo_rp_q;
      fifo_cnt_q <= 2'(fifo_cnt_q + {1'b0, cap_go} - {1'b0, fifo_pop});
    end
  end

  // byte serializer, most significant byte first
  wlm_ser_state_t ser_q;
  logic [23:0]    ser_word_q;
  assign fifo_pop = (ser_q == WLM_SER_IDLE) && fifo_out_vld;
  wire byte_take  = o_wave_byte_valid && i_wave_byte_ready;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ser_q      <= WLM_SER_IDLE;
      ser_word_q <= '0;
    end else begin
      case (ser_q)
        WLM_SER_IDLE: if (fifo_pop) begin
          ser_word_q <= fifo_mem_q[fifo_rp_q];
          ser_q      <= WLM_SER_HI;
        end
        WLM_SER_HI:  if (byte_take) ser_q <= WLM_SER_MID;    // see RL6
        WLM_SER_MID: if (byte_take) ser_q <= WLM_SER_LO;
        WLM_SER_LO:  if (byte_take) ser_q <= WLM_SER_IDLE;
        default:     ser_q <= WLM_SER_IDLE;
      endcase
    end
  end
  assign o_wave_byte_valid = (ser_q != WLM_SER_IDLE);
  assign o_wave_byte = (ser_q == WLM_SER_HI)  ? ser_word_q[23:16] :
                       (ser_q == WLM_SER_MID) ? ser_word_q[15:8]  :
                       (ser_q == WLM_SER_LO)  ? ser_word_q[7:0]   : 8'h00;

  // status flags: hardware set wins over the clear-on-read
  wire [9:0] st_set = {zx_ev,                               // see RL12
                       to_ev | ~zx_sel,                     // see RL18
                       sag_ev,
                       cap_go};                             // see RL4
  wire [9:0] st_keep = cor_rd ? 10'h000 : status_q;          // see RL14
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      status_q <= 10'h000;
    else
      status_q <= st_keep | st_set;
  end

  // interrupt: flags gated by enables; timeout uses the sag enables
  wire [9:0] irq_gate = {irq_en_q[9:7] & zx_sel,            // see RL13 see RL15
                         irq_en_q[3:1] & zx_sel,            // see RL17
                         irq_en_q[3:1],                     // see RL22
                         irq_en_q[0]};
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_irq_n <= 1'b1;
    else
      o_irq_n <= !(|(status_q & irq_gate));                 // see RL26 see RL7
  end
  assign o_irq_oe = !o_irq_n;

endmodule : wlm_top
`default_nettype wire

// *** bench/wlm_top_chk.sv ***
// port checker for the line monitor top
`timescale 1ns/1ps
`default_nettype none
module wlm_top_chk
  import wlm_pkg::*;
(
  input wire logic         i_clk,             // clock
  input wire logic         i_sys_rst,         // reset
  input wire logic         i_smp_valid,       // sample strobe
  input wire wlm_reg_req_t i_reg,             // register request
  input wire logic [15:0]  o_reg_rdata,       // read data
  input wire logic         o_cur_valid,       // scaled strobe
  input wire logic [7:0]   o_wave_byte,       // byte out
  input wire logic         o_wave_byte_valid, // byte offered
  input wire logic         i_wave_byte_ready, // byte taken
  input wire logic         o_irq_n,           // irq, active low
  input wire logic         o_irq_oe           // pin pull
);
  logic [1:0] cnt_q;  // bytes of the word taken
  logic [1:0] cnt_d;
  wire        take = o_wave_byte_valid && i_wave_byte_ready;
  wire        clr  = i_reg.wr || (i_reg.rd && i_reg.addr == 6'h11);
  // counts bytes so word ends are known
  assign cnt_d = !take ? cnt_q : (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) cnt_q <= 2'h0;
    else cnt_q <= cnt_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence taken_mid; take && cnt_q != 2'h2; endsequence
  sequence taken_last; take && cnt_q == 2'h2; endsequence
  sequence quiet_low; !clr ##1 !o_irq_n; endsequence
  // pin, strobes, stream and irq relations
  pin_drive_a: assert property (o_irq_oe == !o_irq_n)
    else $error("pin drive differs from irq");
  cur_valid_a: assert property (o_cur_valid == $past(i_smp_valid))
    else $error("scaled strobe not one cycle after sample");
  byte_hold_a: assert property (o_wave_byte_valid && !i_wave_byte_ready |=>
    o_wave_byte_valid && $stable(o_wave_byte)) else $error("byte dropped while stalled");
  byte_burst_a: assert property (taken_mid |=> o_wave_byte_valid)
    else $error("word broken off");
  word_gap_a: assert property (taken_last |=> !o_wave_byte_valid)
    else $error("no idle after word");
  irq_hold_a: assert property (quiet_low |=> !o_irq_n)
    else $error("irq released without clear");
  irq_release_a: assert property ($rose(o_irq_n) |-> $past(clr, 2))
    else $error("irq rose without cause");
  rdata_hold_a: assert property (!i_reg.rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (i_reg.rd && i_reg.addr == 6'h3F |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : wlm_top_chk
`default_nettype wire

// *** bench/wlm_host_model.sv ***
// host side: takes waveform bytes, can stall, rebuilds words
`timescale 1ns/1ps
`default_nettype none
module wlm_host_model (
  input  wire logic       i_clk,     // clock
  input  wire logic       i_sys_rst, // reset
  input  wire logic [7:0] i_byte,    // offered byte
  input  wire logic       i_valid,   // byte offered
  input  wire logic       i_stall,   // hold off
  output logic            o_ready,   // byte taken
  output logic [23:0]     o_word,    // rebuilt word
  output logic            o_word_stb // word complete
);
  logic [1:0] cnt_q;  // bytes taken of this word
  // slow host simply withholds ready
  assign o_ready = !i_stall;
  // first byte ends on top of the word
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q      <= 2'h0;
      o_word     <= 24'h000000;
      o_word_stb <= 1'b0;
    end else begin
      o_word_stb <= i_valid && o_ready && cnt_q == 2'h2;
      if (i_valid && o_ready) begin
        o_word <= {o_word[15:0], i_byte};
        cnt_q  <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      end
    end
  end
endmodule : wlm_host_model
`default_nettype wire

// *** bench/waveform_line_monitor_test.sv ***
// self-checking bench for the waveform line monitor
`timescale 1ns/1ps
`default_nettype none
module waveform_line_monitor_test
  import wlm_pkg::*;
  ;
  logic         i_clk = 1'b0;
  logic         i_sys_rst = 1'b1;
  logic         i_smp_valid = 1'b0;
  wlm_cur_t     i_cur_raw = '0;
  wlm_volt_t    i_volt_raw = '0;
  wlm_reg_req_t i_reg = '0;
  logic         stall = 1'b0;
  logic [15:0]  o_reg_rdata;
  wlm_cur_t     o_cur_scaled;
  logic         o_cur_valid, o_wave_byte_valid, wave_ready, o_irq_n, o_irq_oe, word_stb;
  logic [7:0]   o_wave_byte;
  logic [23:0]  word;
  logic [15:0]  rd;
  logic signed [11:0] g[3];
  int           fail_count = 0;
  int           check_count = 0;
  int unsigned  seed = 92547;
  logic [23:0]  exp_q[$];
  logic [5:0]   ra[7] = '{6'h0B, 6'h0C, 6'h0F, 6'h12, 6'h13, 6'h14, 6'h3F};
  logic [15:0]  rv[7] = '{16'h0070, 16'h0000, 16'h0000, 16'hFFFF, 16'h00FF, 16'h0000, 16'h0000};
  always #50 i_clk = ~i_clk;
  wlm_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_smp_valid(i_smp_valid),
    .i_cur_raw(i_cur_raw), .i_volt_raw(i_volt_raw), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
    .o_cur_scaled(o_cur_scaled), .o_cur_valid(o_cur_valid), .o_wave_byte(o_wave_byte),
    .o_wave_byte_valid(o_wave_byte_valid), .i_wave_byte_ready(wave_ready),
    .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe));
  wlm_host_model host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_byte(o_wave_byte),
    .i_valid(o_wave_byte_valid), .i_stall(stall), .o_ready(wave_ready), .o_word(word),
    .o_word_stb(word_stb));
  function automatic logic [23:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[23:0];
  endfunction : rnd
  // clamp then scale by one plus gain over 4096
  function automatic logic [23:0] scl(logic signed [23:0] x, logic signed [11:0] gn);
    longint c;
    c = x;
    c = (c > 64'sh400000) ? 64'sh400000 : (c < -64'sh400000) ? -64'sh400000 : c;
    c = (c * (4096 + gn)) >>> 12;
    return c[23:0];
  endfunction : scl
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask : tick
  task automatic chk(logic [23:0] got, logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(logic [5:0] a, logic [15:0] d);
    i_reg = '{1'b1, 1'b0, a, d};
    tick(1);
    i_reg = '0;
    tick(1); // idle cycle so the next request never lands in the same step
  endtask : wreg
  task automatic rreg(logic [5:0] a);
    i_reg = '{1'b0, 1'b1, a, 16'h0000};
    tick(1);
    i_reg = '0;
    rd = o_reg_rdata;
    tick(1); // idle cycle so the next request never lands in the same step
  endtask : rreg
  // n samples, all phases at voltage v, twelve cycles apart
  task automatic smp(int n, logic [15:0] v);
    repeat (n) begin
      i_volt_raw = {3{v}};
      i_smp_valid = 1'b1;
      tick(1);
      i_smp_valid = 1'b0;
      tick(11);
    end
  endtask : smp
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // every rebuilt word must be the next one the model holds
  always @(negedge i_clk) begin
    if (word_stb) chk(word, exp_q.size() ? exp_q.pop_front() : 24'hFFFFFF);
  end
  // cut a hang short
  initial begin
    repeat (30000) @(posedge i_clk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    #10 i_sys_rst = 1'b0;
    foreach (ra[k]) begin
      rreg(ra[k]);
      chk(24'(rd), 24'(rv[k]));
    end
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      for (int p = 0; p < 3; p++) begin
        g[p] = 12'(rnd());
        wreg(6'(25 + p), {4'h0, g[p]});
        i_cur_raw[p] = rnd();
      end
      i_smp_valid = 1'b1;
      tick(1);
      i_smp_valid = 1'b0;
      for (int p = 0; p < 3; p++) chk(o_cur_scaled[p], scl(i_cur_raw[p], g[p]));
    end
    $display("test current scaling done");
    wreg(6'h0C, 16'h0003);
    smp(200, 16'hEDCC);
    rreg(6'h01);
    chk(24'({rd, o_irq_n}), 24'h1);
    wreg(6'h0F, 16'h0001);
    for (int r = 0; r < 4; r++) begin
      wreg(6'h0C, 16'(r * 8 + 3));
      repeat (8 >> r) exp_q.push_back(24'h00EDCC);
      smp(8, 16'hEDCC);
      chk(24'(exp_q.size()), 24'h0);
    end
    chk(24'(o_irq_n), 24'h0);
    rreg(6'h11);
    tick(2);
    chk(24'({rd[0], o_irq_n}), 24'h3);
    rreg(6'h01);
    chk(24'(rd), 24'h00EDCC);
    $display("test capture rates done");
    wreg(6'h0C, 16'h0003);
    stall = 1'b1;
    repeat (3) exp_q.push_back(24'h00EDCC);
    smp(6, 16'hEDCC);
    stall = 1'b0;
    tick(20);
    chk(24'(exp_q.size()), 24'h0);
    // capture of the scaled phase a current
    wreg(6'h0C, 16'h0000);
    exp_q.push_back(scl(i_cur_raw[0], g[0]));
    smp(1, 16'hEDCC);
    chk(24'(exp_q.size()), 24'h0);
    $display("test stalled stream done");
    wreg(6'h0F, 16'h0000);
    wreg(6'h12, 16'h0002);
    rreg(6'h11);
    smp(60, 16'h1234);
    tick(800);
    rreg(6'h10);
    chk(24'({rd, o_irq_n}), 24'h07E1);
    wreg(6'h0F, 16'h0380);
    tick(2);
    chk(24'(o_irq_n), 24'h0);
    rreg(6'h11);
    tick(2);
    rreg(6'h10);
    chk(24'({rd, o_irq_n}), 24'h1);
    wreg(6'h0B, 16'h0003);
    tick(2);
    rreg(6'h10);
    chk(24'(rd), 24'h0070);
    smp(60, 16'hEDCC);
    smp(60, 16'h1234);
    chk(24'(o_irq_n), 24'h1);
    $display("test crossings done");
    wreg(6'h0B, 16'h0070);
    wreg(6'h12, 16'hFFFF);
    wreg(6'h0F, 16'h000E);
    wreg(6'h14, 16'h0028);
    wreg(6'h13, 16'h0002);
    rreg(6'h11);
    repeat (6) begin
      smp(40, 16'h0800);
      smp(40, 16'hF800);
    end
    rreg(6'h10);
    chk(24'({rd[3:1], o_irq_n}), 24'hE);
    rreg(6'h07);
    chk(24'(rd[14:0] >= 15'd39 && rd[14:0] <= 15'd41), 24'h1);
    $display("test sag and period done");
    finish_test();
  end
endmodule : waveform_line_monitor_test
bind wlm_top wlm_top_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_smp_valid(i_smp_valid), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
  .o_cur_valid(o_cur_valid), .o_wave_byte(o_wave_byte), .o_wave_byte_valid(o_wave_byte_valid),
  .i_wave_byte_ready(i_wave_byte_ready), .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe));
`default_nettype wire
